// *** core/ltrt_defines.vh ***
/*
 * Constants for the level trigger and reading transfer block: command codes,
 * full-scale table, power-on values and field positions of the command argument.
 * Assumes inclusion by bare name from the core modules and the test bench.
 */
// How it works
// RL1 - with level source armed, a threshold crossing in chosen direction starts measuring
// RL2 - threshold is signed whole percent, -128 to +127, step one percent
// RL3 - threshold powers up at zero percent until the host changes it
// RL4 - autorange keeps the percent; absolute level follows the range in use
// RL5 - direction picks rising or falling crossings as the trigger event
// RL6 - voltage full scales are 40 mV, 320 mV, 2.56 V, 10.24 V
// RL7 - only dc voltage and three fast resistance functions are accepted
// RL8 - expected maximum picks the range; zero selects autoranging
// RL9 - configure autozeroes once at start; autozero command autozeroes once too
// RL10 - host gives an explicit transfer count between 1 and 2147483647
// RL11 - counted transfer passes each reading on as it arrives, until count met
// RL12 - uncounted transfer waits for scan end, counts stored readings, sends all
// RL13 - any programming command except interrupt enable/disable and transfer empties the buffer
// RL14 - host never asks for bulk transfer during high-level measure commands
// RL15 - host sends one command per line and reads data promptly
// RL16 - power-on selects rear terminals; configure switches to the internal path
// RL17 - threshold is percent times active full scale, compared signed per sample
// RL18 - crossing needs two successive samples on opposite sides, in chosen direction
`ifndef LTRT_DEFINES_VH
`define LTRT_DEFINES_VH

`define LTRT_CMD_TRIGGER_THRESHOLD_PERCENT 4'h0
`define LTRT_CMD_SLOPE 4'h1
`define LTRT_CMD_FUNCTION_SELECT 4'h2
`define LTRT_CMD_AUTOZERO_COMMAND 4'h3
`define LTRT_CMD_CONFIGURE_COMMAND 4'h4
`define LTRT_CMD_TERM 4'h5
`define LTRT_CMD_TRIG 4'h6
`define LTRT_CMD_READING_COUNT 4'h7
`define LTRT_CMD_XFER 4'h8
`define LTRT_CMD_INTR_EN 4'h9
`define LTRT_CMD_INTR_DIS 4'hA

`define LTRT_FN_DCV 3'h0
`define LTRT_FN_OHM_LOW 3'h1
`define LTRT_FN_OHM_MID 3'h2
`define LTRT_FN_OHM_HIGH 3'h3

// argument fields
`define LTRT_ARG_FN_HI 26
`define LTRT_ARG_FN_LO 24
`define LTRT_ARG_MAX_HI 20
`define LTRT_ARG_MAX_LO 0
`define LTRT_ARG_TRIGGER_THRESHOLD_PERCENT_HI 7
`define LTRT_ARG_TRIGGER_THRESHOLD_PERCENT_LO 0
`define LTRT_ARG_FLAG 0

// full scales: volts in 10 uV units, ohms in ohm units
`define LTRT_FS_V0 21'h000FA0
`define LTRT_FS_V1 21'h007D00
`define LTRT_FS_V2 21'h03E800
`define LTRT_FS_V3 21'h0FA000
`define LTRT_FS_R0 21'h002710
`define LTRT_FS_R1 21'h0186A0
`define LTRT_FS_R2 21'h0F4240
`define LTRT_PCT_SCALE 40'sh0000000064

// power-on values
`define LTRT_TRIGGER_THRESHOLD_PERCENT_RST 8'h00
`define LTRT_RISING_RST 1'b1
`define LTRT_FN_RST 3'h0
`define LTRT_READING_COUNT_RST 16'h0001
`define LTRT_REAR_RST 1'b1

`endif

// *** core/ltrt_range_select.v ***
/*
 * Full-scale and range selection for the active function.
 * Assumes the converter reports its present range index while autoranging.
 */
`include "ltrt_defines.vh"

module ltrt_range_select (
	input wire [2:0] function_select,
	input wire [20:0] expected_max,
	input wire autorange,
	input wire [1:0] converter_range,
	output reg [1:0] range_index,
	output reg [20:0] full_scale
);
	always @* begin
		range_index = 2'h3;
		if (function_select == `LTRT_FN_DCV) begin
			if (autorange)
				range_index = converter_range; // RL4
			else if (expected_max <= `LTRT_FS_V0)
				range_index = 2'h0; // RL8
			else if (expected_max <= `LTRT_FS_V1)
				range_index = 2'h1;
			else if (expected_max <= `LTRT_FS_V2)
				range_index = 2'h2;
			case (range_index) // RL6
				2'h0: full_scale = `LTRT_FS_V0;
				2'h1: full_scale = `LTRT_FS_V1;
				2'h2: full_scale = `LTRT_FS_V2;
				default: full_scale = `LTRT_FS_V3;
			endcase
		end else begin
			range_index = function_select[1:0] - 2'h1;
			case (function_select)
				`LTRT_FN_OHM_LOW: full_scale = `LTRT_FS_R0;
				`LTRT_FN_OHM_MID: full_scale = `LTRT_FS_R1;
				default: full_scale = `LTRT_FS_R2;
			endcase
		end
	end
endmodule // ltrt_range_select

// *** core/ltrt_level_detect.v ***
/*
 * Level crossing detector: signed percent of full scale against each sample.
 * Assumes one sample per sample_valid pulse, in the units of the full scale.
 */
`include "ltrt_defines.vh"

module ltrt_level_detect #(
	parameter SAMPLE_W = 24
) (
	input wire clk,
	input wire rst,
	input wire restart,
	input wire sample_valid,
	input wire [SAMPLE_W-1:0] sample,
	input wire [7:0] trigger_threshold_percent,
	input wire [20:0] full_scale,
	input wire rising_direction,
	output wire crossing
);
	wire signed [39:0] sample_ext;
	wire signed [39:0] sample_scaled;
	wire signed [39:0] trigger_threshold_percent_ext;
	wire signed [39:0] fs_ext;
	wire signed [39:0] level;
	wire above;
	reg prev_above;
	reg prev_ok;

	assign sample_ext = {{(40-SAMPLE_W){sample[SAMPLE_W-1]}}, sample};
	assign sample_scaled = sample_ext * `LTRT_PCT_SCALE;
	assign trigger_threshold_percent_ext = {{32{trigger_threshold_percent[7]}}, trigger_threshold_percent};
	assign fs_ext = {19'h00000, full_scale};
	// percent times full scale, both sides scaled by 100
	assign level = trigger_threshold_percent_ext * fs_ext; // RL17
	assign above = sample_scaled >= level; // RL17

	// RL18
	assign crossing = sample_valid && prev_ok && !restart &&
		(rising_direction ? (above && !prev_above) : (!above && prev_above)); // RL5

	always @(posedge clk) begin
		if (rst || restart) begin
			prev_ok <= 1'b0;
			prev_above <= 1'b0;
		end else if (sample_valid) begin
			prev_ok <= 1'b1;
			prev_above <= above;
		end
	end
endmodule // ltrt_level_detect

// *** core/ltrt_top.v ***
/*
 * Level trigger, measurement sequencing, reading buffer and bulk transfer.
 * Assumes commands arrive as single-cycle strobes with argument, samples
 * come from the converter one per sample_valid, and the host drains readings
 * with a valid/ready handshake.
 */
`include "ltrt_defines.vh"

module ltrt_top #(
	parameter SAMPLE_W = 24,
	parameter DEPTH = 16,
	parameter PTR_W = 4
) (
	input wire clk,
	input wire rst,
	input wire cmd_valid,
	input wire [3:0] cmd_code,
	input wire [31:0] cmd_arg,
	output reg cmd_error,
	input wire sample_valid,
	input wire [SAMPLE_W-1:0] sample,
	input wire [1:0] converter_range,
	output reg [1:0] range_select,
	output reg [20:0] active_full_scale,
	output reg autorange,
	output reg [2:0] function_select,
	output reg [7:0] trigger_threshold_percent,
	output reg rising_direction,
	output reg level_source,
	output reg rear_terminal_input,
	output reg autozero_start,
	output reg measure_start,
	output reg measuring,
	output reg scan_complete,
	output reg interrupt_enable,
	output reg [15:0] reading_count,
	output reg [PTR_W:0] stored_count,
	output reg transfer_busy,
	output reg reading_valid,
	output reg [SAMPLE_W-1:0] reading_data,
	input wire reading_ready
);
	localparam ST_IDLE = 2'h0;
	localparam ST_ARMED = 2'h1;
	localparam ST_MEAS = 2'h2;

	localparam XS_IDLE = 2'h0;
	localparam XS_COUNT = 2'h1;
	localparam XS_WAIT_ALL = 2'h2;

	reg [1:0] state;
	reg [1:0] next_state;
	reg [1:0] xstate;
	reg [20:0] expected_max;
	reg [15:0] taken;
	reg [30:0] remaining;
	reg [SAMPLE_W-1:0] mem [0:DEPTH-1];
	reg [PTR_W-1:0] wr_ptr;
	reg [PTR_W-1:0] rd_ptr;

	wire [1:0] range_index;
	wire [20:0] full_scale;
	wire crossing;
	wire fn_ok;
	wire clears_buffer;
	wire is_cmd;
	wire buf_full;
	wire buf_empty;
	wire push;
	wire pop;
	wire out_free;
	wire [2:0] arg_fn;

	assign is_cmd = cmd_valid;
	assign arg_fn = cmd_arg[`LTRT_ARG_FN_HI:`LTRT_ARG_FN_LO];
	// RL7
	assign fn_ok = (arg_fn == `LTRT_FN_DCV) || (arg_fn == `LTRT_FN_OHM_LOW) ||
		(arg_fn == `LTRT_FN_OHM_MID) || (arg_fn == `LTRT_FN_OHM_HIGH);
	// RL13
	assign clears_buffer = is_cmd && (cmd_code != `LTRT_CMD_INTR_EN) &&
		(cmd_code != `LTRT_CMD_INTR_DIS) && (cmd_code != `LTRT_CMD_XFER);
	assign buf_full = stored_count == DEPTH[PTR_W:0];
	assign buf_empty = stored_count == {(PTR_W+1){1'b0}};
	// readings taken only while a scan runs; a full buffer aborts the scan
	assign push = (state == ST_MEAS) && sample_valid && !buf_full && !clears_buffer;
	assign out_free = !reading_valid || reading_ready;
	// RL11
	assign pop = (xstate == XS_COUNT) && out_free && !buf_empty &&
		(remaining != 31'h00000000) && !clears_buffer;

	ltrt_range_select u_range (
		.function_select(function_select),
		.expected_max(expected_max),
		.autorange(autorange),
		.converter_range(converter_range),
		.range_index(range_index),
		.full_scale(full_scale)
	);

	ltrt_level_detect #(
		.SAMPLE_W(SAMPLE_W)
	) u_detect (
		.clk(clk),
		.rst(rst),
		.restart(state != ST_ARMED),
		.sample_valid(sample_valid),
		.sample(sample),
		.trigger_threshold_percent(trigger_threshold_percent),
		.full_scale(full_scale),
		.rising_direction(rising_direction),
		.crossing(crossing)
	);

	// programming registers
	always @(posedge clk) begin
		if (rst) begin
			trigger_threshold_percent <= `LTRT_TRIGGER_THRESHOLD_PERCENT_RST; // RL3
			rising_direction <= `LTRT_RISING_RST;
			function_select <= `LTRT_FN_RST;
			expected_max <= 21'h000000;
			autorange <= 1'b1;
			level_source <= 1'b0;
			rear_terminal_input <= `LTRT_REAR_RST; // RL16
			reading_count <= `LTRT_READING_COUNT_RST;
			interrupt_enable <= 1'b0;
			cmd_error <= 1'b0;
			autozero_start <= 1'b0;
			range_select <= 2'h0;
			active_full_scale <= 21'h000000;
		end else begin
			autozero_start <= 1'b0;
			cmd_error <= 1'b0;
			range_select <= range_index;
			active_full_scale <= full_scale; // RL4
			if (is_cmd) begin
				case (cmd_code)
					`LTRT_CMD_TRIGGER_THRESHOLD_PERCENT:
						trigger_threshold_percent <=
							cmd_arg[`LTRT_ARG_TRIGGER_THRESHOLD_PERCENT_HI:`LTRT_ARG_TRIGGER_THRESHOLD_PERCENT_LO]; // RL2
					`LTRT_CMD_SLOPE:
						rising_direction <= cmd_arg[`LTRT_ARG_FLAG]; // RL5
					`LTRT_CMD_FUNCTION_SELECT: begin
						if (fn_ok) begin
							function_select <= arg_fn;
							expected_max <= cmd_arg[`LTRT_ARG_MAX_HI:`LTRT_ARG_MAX_LO];
							autorange <=
								cmd_arg[`LTRT_ARG_MAX_HI:`LTRT_ARG_MAX_LO] == 21'h000000; // RL8
						end else begin
							cmd_error <= 1'b1; // RL7
						end
					end
					`LTRT_CMD_AUTOZERO_COMMAND:
						autozero_start <= 1'b1; // RL9
					`LTRT_CMD_CONFIGURE_COMMAND: begin
						if (fn_ok) begin
							function_select <= arg_fn;
							expected_max <= 21'h000000;
							autorange <= 1'b1;
							rear_terminal_input <= 1'b0; // RL16
							autozero_start <= 1'b1; // RL9
						end else begin
							cmd_error <= 1'b1; // RL7
						end
					end
					`LTRT_CMD_TERM:
						rear_terminal_input <= cmd_arg[`LTRT_ARG_FLAG];
					`LTRT_CMD_TRIG:
						level_source <= cmd_arg[`LTRT_ARG_FLAG];
					`LTRT_CMD_READING_COUNT: begin
						if (cmd_arg[15:0] == 16'h0000)
							cmd_error <= 1'b1;
						else
							reading_count <= cmd_arg[15:0];
					end
					`LTRT_CMD_INTR_EN:
						interrupt_enable <= 1'b1;
					`LTRT_CMD_INTR_DIS:
						interrupt_enable <= 1'b0;
					default: begin
					end
				endcase
			end
		end
	end

	// measurement sequence
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (is_cmd && cmd_code == `LTRT_CMD_TRIG)
					next_state = cmd_arg[`LTRT_ARG_FLAG] ? ST_ARMED : ST_MEAS;
			end
			ST_ARMED: begin
				if (crossing)
					next_state = ST_MEAS; // RL1
			end
			ST_MEAS: begin
				if (push && taken == reading_count - 16'h0001)
					next_state = ST_IDLE;
				else if (buf_full && sample_valid)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
		// reprogramming by any buffer-clearing command but a trigger command abandons any scan in progress
		if (clears_buffer && !(cmd_code == `LTRT_CMD_TRIG))
			next_state = ST_IDLE;
	end

	always @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
			taken <= 16'h0000;
			measure_start <= 1'b0;
			measuring <= 1'b0;
			scan_complete <= 1'b0;
		end else begin
			state <= next_state;
			measure_start <= (state != ST_MEAS) && (next_state == ST_MEAS); // RL1
			measuring <= next_state == ST_MEAS;
			if (next_state == ST_MEAS && state != ST_MEAS)
				taken <= 16'h0000;
			else if (push)
				taken <= taken + 16'h0001;
			if (clears_buffer)
				scan_complete <= 1'b0;
			else if (state == ST_MEAS && next_state == ST_IDLE)
				scan_complete <= 1'b1;
		end
	end

	// reading buffer
	always @(posedge clk) begin
		if (push)
			mem[wr_ptr] <= sample;
	end

	always @(posedge clk) begin
		if (rst || clears_buffer) begin
			wr_ptr <= {PTR_W{1'b0}}; // RL13
			rd_ptr <= {PTR_W{1'b0}};
			stored_count <= {(PTR_W+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
			if (pop)
				rd_ptr <= rd_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
			if (push && !pop)
				stored_count <= stored_count + {{PTR_W{1'b0}}, 1'b1};
			else if (pop && !push)
				stored_count <= stored_count - {{PTR_W{1'b0}}, 1'b1};
		end
	end

	// bulk transfer
	always @(posedge clk) begin
		if (rst || clears_buffer) begin
			xstate <= XS_IDLE;
			remaining <= 31'h00000000;
			transfer_busy <= 1'b0;
			reading_valid <= 1'b0;
			reading_data <= {SAMPLE_W{1'b0}};
		end else begin
			if (reading_valid && reading_ready)
				reading_valid <= 1'b0;
			if (pop) begin
				reading_valid <= 1'b1;
				reading_data <= mem[rd_ptr];
			end
			case (xstate)
				XS_IDLE: begin
					if (is_cmd && cmd_code == `LTRT_CMD_XFER) begin
						transfer_busy <= 1'b1;
						if (cmd_arg[30:0] != 31'h00000000) begin
							remaining <= cmd_arg[30:0]; // RL10
							xstate <= XS_COUNT; // RL11
						end else begin
							xstate <= XS_WAIT_ALL; // RL12
						end
					end
				end
				XS_COUNT: begin
					if (remaining == 31'h00000000) begin
						if (out_free) begin
							xstate <= XS_IDLE;
							transfer_busy <= 1'b0;
						end
					end else if (pop) begin
						remaining <= remaining - 31'h00000001;
					end
				end
				XS_WAIT_ALL: begin
					if (scan_complete) begin
						remaining <= {{(30-PTR_W){1'b0}}, stored_count}; // RL12
						xstate <= XS_COUNT;
					end
				end
				default: xstate <= XS_IDLE;
			endcase
		end
	end
endmodule // ltrt_top

// *** test/ltrt_asserts.sv ***
/* port checker for ltrt_top
   bound from the bench top file; sees top ports only */
module ltrt_asserts #(
	parameter SAMPLE_W = 24,
	parameter PTR_W = 4
) (
	input wire clk,
	input wire rst,
	input wire cmd_valid,
	input wire [3:0] cmd_code,
	input wire [31:0] cmd_arg,
	input wire cmd_error,
	input wire [1:0] converter_range,
	input wire [1:0] range_select,
	input wire [20:0] active_full_scale,
	input wire autorange,
	input wire [2:0] function_select,
	input wire [7:0] trigger_threshold_percent,
	input wire rear_terminal_input,
	input wire autozero_start,
	input wire scan_complete,
	input wire [PTR_W:0] stored_count,
	input wire reading_valid,
	input wire [SAMPLE_W-1:0] reading_data,
	input wire reading_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// code F is unused, so it marks no command
	wire [3:0] c = cmd_valid ? cmd_code : 4'hF;
	wire bad_fn = cmd_arg[26];
	wire az_cmd = c == 4'h3 || (c == 4'h4 && !bad_fn);
	trigger_threshold_percent_load_a: assert property (
		c == 4'h0 |=> trigger_threshold_percent == $past(cmd_arg[7:0]))
		else $error("threshold not loaded");
	power_on_a: assert property (
		$past(rst) |-> trigger_threshold_percent == 8'h00 && rear_terminal_input)
		else $error("bad power-on values");
	configure_command_rear_a: assert property (
		c == 4'h4 && !bad_fn |=> !rear_terminal_input)
		else $error("configure kept rear input");
	autozero_command_once_a: assert property (az_cmd |=> autozero_start)
		else $error("no autozero");
	autozero_command_cause_a: assert property (autozero_start |-> $past(az_cmd))
		else $error("stray autozero");
	fn_refuse_a: assert property (
		(c == 4'h2 || c == 4'h4) && bad_fn |=> cmd_error && $stable(function_select))
		else $error("bad function accepted");
	clear_buf_a: assert property (
		c inside {4'h0, 4'h1, 4'h3, 4'h5} |=>
		stored_count == 0 && !reading_valid && !scan_complete)
		else $error("buffer not cleared");
	hold_data_a: assert property (
		reading_valid && !reading_ready && !cmd_valid |=>
		reading_valid && $stable(reading_data))
		else $error("reading dropped");
	fs_table_a: assert property (
		$past(function_select) == 3'h0 && !$past(rst) |-> active_full_scale ==
		(range_select == 2'h0 ? 21'h000FA0 : range_select == 2'h1 ? 21'h007D00 :
		range_select == 2'h2 ? 21'h03E800 : 21'h0FA000))
		else $error("wrong full scale");
	range_follow_a: assert property (
		autorange && function_select == 3'h0 && !cmd_valid |=>
		range_select == $past(converter_range) && $stable(trigger_threshold_percent))
		else $error("range not followed");
endmodule // ltrt_asserts

// *** test/ltrt_host.sv ***
/* host model: drains readings with random stalls
   stall comes from the bench, one reading per accepted edge */
module ltrt_host (
	input wire clk,
	input wire rst,
	input wire reading_valid,
	input wire [23:0] reading_data,
	input wire stall,
	output reg reading_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [23:0] got [0:63];
	integer n_got = 0;
	initial reading_ready = 1'b0;
	always @(posedge clk) begin
		reading_ready <= !rst && !stall;
		if (reading_valid && reading_ready) begin
			got[n_got] <= reading_data;
			n_got <= n_got + 1;
		end
	end
endmodule // ltrt_host

// *** test/ltrt_top_test.sv ***
/* self-checking bench for ltrt_top
   needs core on the include path; host model and checker beside it */
`include "ltrt_defines.vh"
`define CK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end
module ltrt_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	reg clk = 0;
	reg rst = 1;
	reg cmd_valid = 0;
	reg [3:0] cmd_code = 4'h0;
	reg [31:0] cmd_arg = 32'h0;
	reg sample_valid = 0;
	reg [23:0] sample = 24'h0;
	reg [1:0] converter_range = 2'h0;
	reg [15:0] sr = 16'h004C;
	reg [7:0] p;
	reg [23:0] q [0:3];
	integer n_fail = 0, num_checks = 0, cyc = 0, i, k, d, b0;
	wire cmd_error, autorange, rising_direction, level_source, rear_terminal_input;
	wire autozero_start, measure_start, measuring, scan_complete, interrupt_enable;
	wire transfer_busy, reading_valid, reading_ready;
	wire [1:0] range_select;
	wire [20:0] active_full_scale;
	wire [2:0] function_select;
	wire [7:0] trigger_threshold_percent;
	wire [15:0] reading_count;
	wire [4:0] stored_count;
	wire [23:0] reading_data;
	always #4 clk = ~clk;
	function [15:0] lf(input [15:0] x);
		lf = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function [20:0] fsv(input [1:0] r);
		fsv = r == 0 ? 21'h000FA0 : r == 1 ? 21'h007D00 : r == 2 ? 21'h03E800 : 21'h0FA000;
	endfunction
	ltrt_top dut_u (.clk, .rst, .cmd_valid, .cmd_code, .cmd_arg, .cmd_error, .sample_valid,
		.sample, .converter_range, .range_select, .active_full_scale, .autorange,
		.function_select, .trigger_threshold_percent, .rising_direction, .level_source,
		.rear_terminal_input, .autozero_start, .measure_start, .measuring, .scan_complete,
		.interrupt_enable, .reading_count, .stored_count, .transfer_busy, .reading_valid,
		.reading_data, .reading_ready);
	ltrt_host host_u (.clk, .rst, .reading_valid, .reading_data, .stall(sr[2]),
		.reading_ready);
	task give_verdict;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		sr <= lf(sr);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			give_verdict();
		end
	end
	task cm(input [3:0] c, input [31:0] a);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_arg <= a;
		@(posedge clk);
		cmd_valid <= 1'b0;
		#1;
	endtask
	task sm(input [23:0] v);
		@(posedge clk);
		sample_valid <= 1'b1;
		sample <= v;
		@(posedge clk);
		sample_valid <= 1'b0;
		#1;
	endtask
	task getn(input integer n);
		for (i = 0; i < 200 && host_u.n_got < b0 + n; i++) begin
			@(posedge clk);
			#1;
		end
		for (k = 0; k < n; k++)
			`CK("reading", q[k], host_u.got[b0 + k])
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		`CK("trigger_threshold_percent", 8'h00, trigger_threshold_percent)
		`CK("rear", 1'b1, rear_terminal_input)
		`CK("dir", 1'b1, rising_direction)
		for (k = 0; k < 11; k++) begin
			p = k == 0 ? 8'h80 : k == 1 ? 8'h7F : k == 2 ? 8'h00 : sr[7:0];
			cm(4'h0, {24'h0, p});
			`CK("trigger_threshold_percent", p, trigger_threshold_percent)
		end
		for (k = 4; k < 8; k++) begin
			cm(4'h2, k << 24);
			`CK("err", 1'b1, cmd_error)
			`CK("fn", 3'h0, function_select)
		end
		for (k = 1; k < 4; k++) begin
			cm(4'h2, k << 24);
			`CK("fn", k[2:0], function_select)
		end
		for (k = 0; k < 4; k++) begin
			cm(4'h2, {11'h0, fsv(k[1:0]) >> 1});
			// range and full scale settle one edge after the setting
			@(posedge clk);
			#1;
			`CK("range", k[1:0], range_select)
			`CK("fs", fsv(k[1:0]), active_full_scale)
		end
		$display("test function done");
		cm(4'h2, 32'h0);
		`CK("auto", 1'b1, autorange)
		for (k = 0; k < 4; k++) begin
			@(posedge clk);
			converter_range <= sr[1:0];
			repeat (2) @(posedge clk);
			#1;
			`CK("range", converter_range, range_select)
			`CK("fs", fsv(converter_range), active_full_scale)
			`CK("trigger_threshold_percent", p, trigger_threshold_percent)
		end
		cm(4'h3, 32'h0);
		`CK("az", 1'b1, autozero_start)
		cm(4'h4, 32'h0);
		`CK("rear", 1'b0, rear_terminal_input)
		`CK("az", 1'b1, autozero_start)
		cm(4'h5, 32'h1);
		`CK("rear", 1'b1, rear_terminal_input)
		$display("test setup done");
		// fixed top range, half scale, falling then rising
		for (d = 0; d < 2; d++) begin
			cm(4'h2, 32'h000C8000);
			cm(4'h0, 32'h00000032);
			cm(4'h1, d);
			cm(4'h7, 32'h3);
			cm(4'h6, 32'h1);
			`CK("src", 1'b1, level_source)
			sm(d ? 24'h061A80 : 24'h0927C0);
			sm(d ? 24'h061A80 : 24'h0927C0);
			`CK("meas", 1'b0, measuring)
			sm(d ? 24'h0927C0 : 24'h061A80);
			`CK("mstart", 1'b1, measure_start)
			for (i = 0; i < 4 && measuring !== 1'b1; i++) begin
				@(posedge clk);
				#1;
			end
			`CK("meas", 1'b1, measuring)
			b0 = host_u.n_got;
			for (k = 0; k < 3; k++) begin
				q[k] = {8'h00, sr};
				sm(q[k]);
			end
			`CK("end", 1'b1, scan_complete)
			cm(4'h8, 32'h0);
			`CK("busy", 1'b1, transfer_busy)
			getn(3);
			`CK("busy", 1'b0, transfer_busy)
		end
		$display("test level done");
		cm(4'h7, 32'h3);
		`CK("reading_count", 16'h0003, reading_count)
		cm(4'h7, 32'h0);
		`CK("err", 1'b1, cmd_error)
		`CK("reading_count", 16'h0003, reading_count)
		cm(4'h6, 32'h0);
		`CK("src", 1'b0, level_source)
		`CK("mstart", 1'b1, measure_start)
		`CK("meas", 1'b1, measuring)
		b0 = host_u.n_got;
		cm(4'h8, 32'h3);
		for (k = 0; k < 3; k++) begin
			q[k] = {8'h00, sr};
			sm(q[k]);
			repeat (3) @(posedge clk);
		end
		getn(3);
		$display("test counted done");
		cm(4'h6, 32'h0);
		sm(24'h000111);
		sm(24'h000222);
		`CK("count", 5'h02, stored_count)
		cm(4'h9, 32'h0);
		`CK("count", 5'h02, stored_count)
		`CK("intr", 1'b1, interrupt_enable)
		cm(4'hA, 32'h0);
		`CK("count", 5'h02, stored_count)
		`CK("intr", 1'b0, interrupt_enable)
		cm(4'h0, 32'h0);
		`CK("count", 5'h00, stored_count)
		$display("test clear done");
		give_verdict();
	end
endmodule // ltrt_top_test
bind ltrt_top ltrt_asserts #(.SAMPLE_W(SAMPLE_W), .PTR_W(PTR_W)) chk_u (.clk, .rst,
	.cmd_valid, .cmd_code, .cmd_arg, .cmd_error, .converter_range, .range_select,
	.active_full_scale, .autorange, .function_select, .trigger_threshold_percent,
	.rear_terminal_input, .autozero_start, .scan_complete, .stored_count, .reading_valid,
	.reading_data, .reading_ready);
